/* hdl/motirq_pkg.sv */
package motirq_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_TAP_FILTER_LATCH_CFG   = 8'h56;
    localparam logic [7:0] ADDR_TAP_X_THR  = 8'h57;
    localparam logic [7:0] ADDR_TAP_Y_THR  = 8'h58;
    localparam logic [7:0] ADDR_TAP_TIMING = 8'h5A;
    localparam logic [7:0] ADDR_WAKE_THR   = 8'h5B;
    localparam logic [7:0] ADDR_WAKE_HOLD_TIME   = 8'h5C;
    localparam logic [7:0] ADDR_PIN_A_RT   = 8'h5E;
    localparam logic [7:0] ADDR_PIN_B_RT   = 8'h5F;
    localparam logic [7:0] ADDR_X_OFS      = 8'h73;
    localparam logic [7:0] ADDR_Y_OFS      = 8'h74;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'h1D;

    // Writable bit masks; reserved bits store and read as zero
    localparam logic [7:0] MASK_TAP_FILTER_LATCH_CFG = 8'h7D;
    localparam logic [7:0] MASK_TAP_X    = 8'h3F;
    localparam logic [7:0] MASK_TAP_Y    = 8'h9F;
    localparam logic [7:0] MASK_WAKE_HOLD_TIME = 8'h7F;
    localparam logic [7:0] MASK_ROUTE    = 8'hEB;
    localparam logic [7:0] RESET_BYTE    = 8'h00;

    // tap_filter_latch_cfg fields
    localparam int CFG0_CLR_ON_READ = 6;
    localparam int CFG0_SLEEP_LEVEL = 5;
    localparam int CFG0_WAKE_FILTER = 4;
    localparam int CFG0_TAP_X_EN    = 3;
    localparam int CFG0_TAP_Y_EN    = 2;
    localparam int CFG0_LATCH       = 0;
    // Threshold registers
    localparam int TAPX_PRIORITY    = 5;
    localparam int TAPY_IRQ_ENABLE  = 7;
    localparam int TAP_THR_MSB      = 4;
    // tap_timing_cfg fields
    localparam int GAP_MSB = 7;
    localparam int GAP_LSB = 4;
    localparam int QUIET_MSB = 3;
    localparam int QUIET_LSB = 2;
    localparam int SHOCK_MSB = 1;
    localparam int SHOCK_LSB = 0;
    // wake_threshold_cfg fields
    localparam int WTHR_DOUBLE_MODE = 7;
    localparam int WTHR_OFS_TO_WAKE = 6;
    localparam int WTHR_MSB         = 5;
    // wake_sleep_duration_cfg fields
    localparam int WDUR_HOLD_MSB = 6;
    localparam int WDUR_HOLD_LSB = 5;
    localparam int WDUR_WEIGHT   = 4;
    localparam int WDUR_SLEEP_MSB = 3;
    // Routing fields (same place on both pins)
    localparam int RT_SLEEP  = 7;
    localparam int RT_SINGLE = 6;
    localparam int RT_WAKE   = 5;
    localparam int RT_DOUBLE = 3;
    localparam int RT_ENGINE = 1;
    localparam int RT_LAST   = 0;

    // Event request indices
    localparam int EV_SINGLE = 0;
    localparam int EV_DOUBLE = 1;
    localparam int EV_WAKE   = 2;
    localparam int EV_SLEEP  = 3;
    localparam int EV_N      = 4;

    // Window lengths in sample ticks
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] SHOCK_ZERO = 13'h0004;
    localparam logic [CNT_W-1:0] SHOCK_STEP = 13'h0008;
    localparam logic [CNT_W-1:0] QUIET_ZERO = 13'h0002;
    localparam logic [CNT_W-1:0] QUIET_STEP = 13'h0004;
    localparam logic [CNT_W-1:0] GAP_ZERO   = 13'h0010;
    localparam logic [CNT_W-1:0] GAP_STEP   = 13'h0020;
    localparam logic [CNT_W-1:0] SLEEP_ZERO = 13'h0010;
    localparam logic [CNT_W-1:0] SLEEP_STEP = 13'h0200;

    // Data scaling: samples are 16-bit with full scale at 2^15
    localparam int DATA_W          = 18;
    localparam int TAP_THR_SHIFT   = 10;
    localparam int WAKE_SHIFT_FS64 = 9;
    localparam int WAKE_SHIFT_FS256 = 7;
    localparam int OFS_SHIFT_FINE  = 2;
    localparam int OFS_SHIFT_COARSE = 6;

    // Tap recognition states
    typedef enum logic [2:0] {
        TAP_IDLE,
        TAP_SHOCK,
        TAP_TOO_LONG,
        TAP_QUIET,
        TAP_GAP
    } motirq_tap_state_t;

endpackage

/* hdl/motirq_top.sv */
`timescale 1ns/1ps
`default_nettype none
module motirq_top (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      reset_n,
    // Register port
    input  wire logic [7:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [7:0]                reg_rdata,
    // Sample stream, one tick per output-data-rate period
    input  wire logic                      sample_tick,
    input  wire logic signed [15:0]        accel_x,
    input  wire logic signed [15:0]        accel_y,
    input  wire logic signed [15:0]        hpf_x,
    input  wire logic signed [15:0]        hpf_y,
    input  wire logic                      offset_step_weight,
    // Other event sources
    input  wire logic                      engine_event,
    input  wire logic                      hub_done,
    input  wire logic                      time_overflow_alert,
    // Interrupt pins
    output logic                           interrupt_pin_a,
    output logic                           interrupt_pin_b
);
    import motirq_pkg::*;

    // Whole block state
    typedef struct packed {
        logic [7:0]             cfg0;      // Filter and latch config
        logic [7:0]             tapx;      // X threshold, priority
        logic [7:0]             tapy;      // Y threshold, irq enable
        logic [7:0]             timing;    // Gap, quiet, shock
        logic [7:0]             wthr;      // Wake threshold, tap mode
        logic [7:0]             wdur;      // Wake hold, sleep time
        logic [7:0]             rt_a;      // Pin A routing
        logic [7:0]             rt_b;      // Pin B routing
        logic [1:0][7:0]        ofs;       // Per-axis user offset
        logic [7:0]             rdata;     // Read answer
        motirq_tap_state_t      tap;       // Tap recognizer state
        logic [CNT_W-1:0]       tap_cnt;   // Tap window counter
        logic                   second;    // Current pulse is second tap
        logic [1:0]             tap_axis;  // Axis of last tap
        logic [1:0][15:0]       prev;      // Previous samples for slope
        logic [2:0]             wake_cnt;  // Consecutive over samples
        logic [CNT_W-1:0]       idle_cnt;  // Inactivity counter
        logic                   sleep;     // Stationary state
        logic [EV_N-1:0]        req;       // Interrupt requests
        logic [EV_N-1:0]        pend;      // Clear due at next tick
        logic                   pin_a;     // Pin A level
        logic                   pin_b;     // Pin B level
    } motirq_state_t;

    motirq_state_t q;  // Registered state
    motirq_state_t d;  // Next state

    // Magnitude of a signed sample
    function automatic logic [DATA_W-1:0] mag(input logic signed [DATA_W-1:0] v);
        mag = v[DATA_W-1] ? DATA_W'(-v) : DATA_W'(v);
    endfunction

    // Per-axis views
    logic signed [1:0][15:0] lp;        // Raw samples by axis
    logic signed [1:0][15:0] hp;        // High-pass samples by axis
    logic [1:0]              axis_en;   // Tap axis enables
    logic [1:0][4:0]         tap_thr;   // Tap thresholds by axis
    logic [1:0]              tap_over;  // Tap threshold exceeded
    logic [1:0]              wake_over; // Wake threshold exceeded
    logic [DATA_W-1:0]       wake_lim;  // Scaled wake threshold

    // Axis 0 is X, axis 1 is Y everywhere below
    assign lp[0]      = accel_x;
    assign lp[1]      = accel_y;
    assign hp[0]      = hpf_x;
    assign hp[1]      = hpf_y;
    assign axis_en[0] = q.cfg0[CFG0_TAP_X_EN];
    assign axis_en[1] = q.cfg0[CFG0_TAP_Y_EN];
    assign tap_thr[0] = q.tapx[TAP_THR_MSB:0];
    assign tap_thr[1] = q.tapy[TAP_THR_MSB:0];

    // Threshold weight chosen by the weight bit
    assign wake_lim = q.wdur[WDUR_WEIGHT]
                    ? (DATA_W'(q.wthr[WTHR_MSB:0]) << WAKE_SHIFT_FS256)
                    : (DATA_W'(q.wthr[WTHR_MSB:0]) << WAKE_SHIFT_FS64);

    // Per-axis offset correction and threshold compare
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_axis
            logic signed [DATA_W-1:0] raw;   // Widened sample
            logic signed [DATA_W-1:0] ofs_s; // Widened offset
            logic signed [DATA_W-1:0] ofs_w; // Weighted offset
            logic signed [DATA_W-1:0] corr;  // Offset-corrected sample
            logic signed [DATA_W-1:0] slope; // Sample-to-sample slope
            logic signed [DATA_W-1:0] hpw;   // Widened high-pass data
            logic signed [DATA_W-1:0] wsrc;  // Wake detector input
            // Packed element selects are unsigned: sign them again
            // so negative samples widen correctly
            assign raw   = DATA_W'($signed(lp[gi]));
            assign ofs_s = DATA_W'($signed(q.ofs[gi]));
            assign ofs_w = offset_step_weight ? (ofs_s <<< OFS_SHIFT_COARSE)
                                              : (ofs_s <<< OFS_SHIFT_FINE);
            assign corr  = raw - ofs_w;
            assign slope = raw - DATA_W'($signed(q.prev[gi]));
            assign hpw   = DATA_W'($signed(hp[gi]));
            // Offset path wins over the filter choice
            assign wsrc  = q.wthr[WTHR_OFS_TO_WAKE] ? corr
                         : (q.cfg0[CFG0_WAKE_FILTER] ? hpw : slope);
            assign tap_over[gi]  = axis_en[gi]
                                 && (mag(corr) > (DATA_W'(tap_thr[gi]) << TAP_THR_SHIFT));
            assign wake_over[gi] = mag(wsrc) > wake_lim;
        end
    endgenerate

    // Window limits from register fields
    logic [CNT_W-1:0] shock_lim;  // Longest over-threshold pulse
    logic [CNT_W-1:0] quiet_lim;  // Quiet window
    logic [CNT_W-1:0] gap_lim;    // Double-tap gap
    logic [CNT_W-1:0] sleep_lim;  // Inactivity time
    logic [2:0]       hold_lim;   // Wake hold time

    // Zero field gives the short default, else field times step; hold limit is the field itself
    always_comb begin
        shock_lim = (q.timing[SHOCK_MSB:SHOCK_LSB] == 2'h0) ? SHOCK_ZERO
                  : CNT_W'(q.timing[SHOCK_MSB:SHOCK_LSB]) * SHOCK_STEP;
        quiet_lim = (q.timing[QUIET_MSB:QUIET_LSB] == 2'h0) ? QUIET_ZERO
                  : CNT_W'(q.timing[QUIET_MSB:QUIET_LSB]) * QUIET_STEP;
        gap_lim   = (q.timing[GAP_MSB:GAP_LSB] == 4'h0) ? GAP_ZERO
                  : CNT_W'(q.timing[GAP_MSB:GAP_LSB]) * GAP_STEP;
        sleep_lim = (q.wdur[WDUR_SLEEP_MSB:0] == 4'h0) ? SLEEP_ZERO
                  : CNT_W'(q.wdur[WDUR_SLEEP_MSB:0]) * SLEEP_STEP;
        hold_lim  = 3'(q.wdur[WDUR_HOLD_MSB:WDUR_HOLD_LSB]);
    end

    // Derived controls
    logic             any_tap;     // Some enabled axis over threshold
    logic             any_wake;    // Some axis over wake threshold
    logic [1:0]       pick_axis;   // Axis reported for this pulse
    logic             status_rd;   // Event status register read
    logic             latch;       // Latch mode
    logic             cor;         // Clear-on-read mode
    logic [EV_N-1:0]  ev;          // Event pulses this cycle
    logic             sleep_src;   // Sleep source toward the pins
    logic [7:0]       src;         // Sources in routing bit order

    assign any_tap   = |tap_over;
    assign any_wake  = |wake_over;
    // Clear-on-read keys on a read of the status register
    assign status_rd = reg_rd && (reg_addr == ADDR_EVT_STATUS);
    assign latch     = q.cfg0[CFG0_LATCH];
    assign cor       = q.cfg0[CFG0_CLR_ON_READ];

    // Both axes over: priority bit names the winner
    always_comb begin
        if (tap_over == 2'b11) begin
            pick_axis = q.tapx[TAPX_PRIORITY] ? 2'b10 : 2'b01;
        end else begin
            // One axis or none: report as it stands
            pick_axis = tap_over;
        end
    end

    // Next-state logic
    always_comb begin
        d  = q;
        ev = '0;

        // Register writes, reserved bits forced low
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_TAP_FILTER_LATCH_CFG:   d.cfg0   = reg_wdata & MASK_TAP_FILTER_LATCH_CFG;
                ADDR_TAP_X_THR:  d.tapx   = reg_wdata & MASK_TAP_X;
                ADDR_TAP_Y_THR:  d.tapy   = reg_wdata & MASK_TAP_Y;
                ADDR_TAP_TIMING: d.timing = reg_wdata;
                ADDR_WAKE_THR:   d.wthr   = reg_wdata;
                ADDR_WAKE_HOLD_TIME:   d.wdur   = reg_wdata & MASK_WAKE_HOLD_TIME;
                ADDR_PIN_A_RT:   d.rt_a   = reg_wdata & MASK_ROUTE;
                ADDR_PIN_B_RT:   d.rt_b   = reg_wdata & MASK_ROUTE;
                // Offset range is kept by software
                ADDR_X_OFS:      d.ofs[0] = reg_wdata;
                ADDR_Y_OFS:      d.ofs[1] = reg_wdata;
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end

        // Register reads, answered next cycle
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_TAP_FILTER_LATCH_CFG:   d.rdata = q.cfg0;
                ADDR_TAP_X_THR:  d.rdata = q.tapx;
                ADDR_TAP_Y_THR:  d.rdata = q.tapy;
                ADDR_TAP_TIMING: d.rdata = q.timing;
                ADDR_WAKE_THR:   d.rdata = q.wthr;
                ADDR_WAKE_HOLD_TIME:   d.rdata = q.wdur;
                ADDR_PIN_A_RT:   d.rdata = q.rt_a;
                ADDR_PIN_B_RT:   d.rdata = q.rt_b;
                ADDR_X_OFS:      d.rdata = q.ofs[0];
                ADDR_Y_OFS:      d.rdata = q.ofs[1];
                // Requests low, then sleep state and tap axes
                ADDR_EVT_STATUS: d.rdata = {1'b0, q.tap_axis[1], q.tap_axis[0], q.sleep, q.req};
                default:         d.rdata = RESET_BYTE;
            endcase
        end

        // Detection runs once per sample tick
        if (sample_tick) begin
            d.prev = lp;

            // Wake: consecutive over samples, restart on a gap
            if (any_wake) begin
                if (q.wake_cnt == hold_lim) begin
                    ev[EV_WAKE] = 1'b1;
                end
                // Stop one past the hold: a long burst fires once
                if (q.wake_cnt <= hold_lim) begin
                    d.wake_cnt = q.wake_cnt + 3'h1;
                end
            end else begin
                d.wake_cnt = '0;
            end

            // Sleep: inactivity count, any motion restarts it
            if (any_wake) begin
                d.idle_cnt = '0;
                if (q.sleep) begin
                    d.sleep        = 1'b0;
                    ev[EV_SLEEP]   = 1'b1;
                end
            end else if (!q.sleep) begin
                if (q.idle_cnt + 13'h0001 >= sleep_lim) begin
                    d.sleep      = 1'b1;
                    d.idle_cnt   = '0;
                    ev[EV_SLEEP] = 1'b1;
                end else begin
                    d.idle_cnt = q.idle_cnt + 13'h0001;
                end
            end

            // Tap recognizer
            unique case (q.tap)
                TAP_IDLE: begin
                    // Pulse start is its first shock tick
                    if (any_tap) begin
                        d.tap      = TAP_SHOCK;
                        d.tap_cnt  = 13'h0001;
                        d.second   = 1'b0;
                        d.tap_axis = pick_axis;
                    end
                end
                TAP_SHOCK: begin
                    if (!any_tap) begin
                        d.tap     = TAP_QUIET;
                        d.tap_cnt = '0;
                    end else if (q.tap_cnt >= shock_lim) begin
                        d.tap = TAP_TOO_LONG;
                    end else begin
                        d.tap_cnt = q.tap_cnt + 13'h0001;
                    end
                end
                TAP_TOO_LONG: begin
                    // Wait for the pulse to end before rearming
                    if (!any_tap) begin
                        d.tap = TAP_IDLE;
                    end
                end
                TAP_QUIET: begin
                    // Any over sample here voids the tap
                    if (any_tap) begin
                        d.tap = TAP_TOO_LONG;
                    end else if (q.tap_cnt + 13'h0001 >= quiet_lim) begin
                        d.tap_cnt = '0;
                        if (q.second) begin
                            ev[EV_DOUBLE] = 1'b1;
                            d.tap         = TAP_IDLE;
                        end else begin
                            ev[EV_SINGLE] = 1'b1;
                            d.tap = q.wthr[WTHR_DOUBLE_MODE] ? TAP_GAP : TAP_IDLE;
                        end
                    end else begin
                        d.tap_cnt = q.tap_cnt + 13'h0001;
                    end
                end
                TAP_GAP: begin
                    // Second pulse must start before the gap ends
                    if (any_tap) begin
                        d.tap      = TAP_SHOCK;
                        d.tap_cnt  = 13'h0001;
                        d.second   = 1'b1;
                        d.tap_axis = pick_axis;
                    end else if (q.tap_cnt + 13'h0001 >= gap_lim) begin
                        d.tap = TAP_IDLE;
                    end else begin
                        d.tap_cnt = q.tap_cnt + 13'h0001;
                    end
                end
            endcase
        end

        // Wake and tap requests need the global enable
        if (!q.tapy[TAPY_IRQ_ENABLE]) begin
            ev[EV_SINGLE] = 1'b0;
            ev[EV_DOUBLE] = 1'b0;
            ev[EV_WAKE]   = 1'b0;
        end

        // Request holding: a new event always beats any clear
        for (int i = 0; i < EV_N; i++) begin
            // Branch order is the priority: set, then clears
            if (ev[i]) begin
                d.req[i] = 1'b1;
            end else if (!latch && sample_tick) begin
                d.req[i] = 1'b0;
            end else if (latch && cor && status_rd) begin
                d.req[i] = 1'b0;
            end else if (latch && !cor && q.pend[i] && sample_tick) begin
                d.req[i] = 1'b0;
            end
            // Read without clear-on-read schedules the clear for the tick
            if (sample_tick || ev[i]) begin
                d.pend[i] = 1'b0;
            end else if (latch && !cor && status_rd && q.req[i]) begin
                d.pend[i] = 1'b1;
            end
        end

        // Pins: OR of routed sources, one cycle behind the requests
        d.pin_a = |(src & q.rt_a);
        d.pin_b = |(src & q.rt_b);
    end

    // Sleep shown as level or change, per mode bit
    assign sleep_src = q.cfg0[CFG0_SLEEP_LEVEL] ? q.sleep : q.req[EV_SLEEP];

    // Sources in routing bit order; last bit differs per pin
    always_comb begin
        src            = '0;
        src[RT_SLEEP]  = sleep_src;
        src[RT_SINGLE] = q.req[EV_SINGLE];
        src[RT_WAKE]   = q.req[EV_WAKE];
        src[RT_DOUBLE] = q.req[EV_DOUBLE];
        src[RT_ENGINE] = engine_event;
        src[RT_LAST]   = 1'b0;
    end

    // Per-pin last source merged after routing
    logic last_a;  // Hub done routed to pin A
    logic last_b;  // Timestamp alert routed to pin B
    assign last_a = hub_done && q.rt_a[RT_LAST];
    assign last_b = time_overflow_alert && q.rt_b[RT_LAST];

    // State register, synchronous reset
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q       <= d;
            // Hub and alert levels join after routing
            q.pin_a <= d.pin_a | last_a;
            q.pin_b <= d.pin_b | last_b;
        end
    end

    // Outputs straight from state flops
    assign reg_rdata       = q.rdata;
    assign interrupt_pin_a = q.pin_a;
    assign interrupt_pin_b = q.pin_b;

endmodule
`default_nettype wire

/* verification/motirq_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module motirq_assertions import motirq_pkg::*; (
    input wire logic       core_clk, reset_n, reg_wr, reg_rd, engine_event, hub_done, time_overflow_alert,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic       interrupt_pin_a, interrupt_pin_b
);
    logic [7:0] cfg_q, ra_q, rb_q; // Shadows of written config
    logic       en_q;              // Global enable seen since reset
    wire        st_rd = reg_rd && reg_addr == ADDR_EVT_STATUS;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Mirror writes so pin checks know the routing
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            {cfg_q, ra_q, rb_q, en_q} <= '0;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_TAP_FILTER_LATCH_CFG) cfg_q <= reg_wdata & MASK_TAP_FILTER_LATCH_CFG;
            if (reg_addr == ADDR_PIN_A_RT) ra_q <= reg_wdata & MASK_ROUTE;
            if (reg_addr == ADDR_PIN_B_RT) rb_q <= reg_wdata & MASK_ROUTE;
            if (reg_addr == ADDR_TAP_Y_THR && reg_wdata[TAPY_IRQ_ENABLE]) en_q <= 1'b1;
        end
    end
    a_cfg_read_back: assert property (reg_rd && reg_addr == ADDR_TAP_FILTER_LATCH_CFG |=> reg_rdata == $past(cfg_q))
        else $error("config readback wrong");
    a_route_a_read: assert property (reg_rd && reg_addr == ADDR_PIN_A_RT |=> reg_rdata == $past(ra_q))
        else $error("pin a routing readback wrong");
    a_route_b_read: assert property (reg_rd && reg_addr == ADDR_PIN_B_RT |=> reg_rdata == $past(rb_q))
        else $error("pin b routing readback wrong");
    a_engine_to_a: assert property (ra_q[RT_ENGINE] && engine_event |=> interrupt_pin_a)
        else $error("engine event missing on pin a");
    a_hub_to_a: assert property (ra_q[RT_LAST] && hub_done |=> interrupt_pin_a)
        else $error("hub done missing on pin a");
    a_alert_to_b: assert property (rb_q[RT_LAST] && time_overflow_alert |=> interrupt_pin_b)
        else $error("overflow alert missing on pin b");
    a_gated_quiet: assert property (!en_q && ((ra_q | $past(ra_q)) & 8'h83) == 8'h00 |-> !interrupt_pin_a)
        else $error("pin a raised while events disabled");
    a_latch_holds: assert property (cfg_q[CFG0_LATCH] && cfg_q[CFG0_CLR_ON_READ] && interrupt_pin_a
        && (ra_q & 8'h83) == 8'h00 && !$past(reg_wr) && !st_rd && !$past(st_rd) |=> interrupt_pin_a)
        else $error("latched request dropped without status read");
endmodule
bind motirq_top motirq_assertions chk_u (.core_clk(core_clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .engine_event(engine_event), .hub_done(hub_done), .time_overflow_alert(time_overflow_alert),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .interrupt_pin_a(interrupt_pin_a), .interrupt_pin_b(interrupt_pin_b));
`default_nettype wire

/* verification/motirq_host.sv */
`timescale 1ns/1ps
`default_nettype none
module motirq_host import motirq_pkg::*; (
    input  wire logic       core_clk,
    output logic [7:0]      reg_addr, reg_wdata,
    output logic            reg_wr, reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    // Software write; data is cleaned the way careful firmware would
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == ADDR_PIN_A_RT || a == ADDR_PIN_B_RT) d = d & MASK_ROUTE;
        if (a == ADDR_TAP_FILTER_LATCH_CFG && !d[CFG0_LATCH]) d[CFG0_CLR_ON_READ] = 1'b0;
        if ((a == ADDR_X_OFS || a == ADDR_Y_OFS) && d == 8'h80) d = 8'h81;
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read answer is registered, so it is taken just after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* verification/motirq_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module motirq_top_bench import motirq_pkg::*;;
    logic core_clk = 1'b0, reset_n = 1'b0, sample_tick = 1'b0, pin_a, pin_b, reg_wr, reg_rd;
    logic engine_event = 1'b0, hub_done = 1'b0, time_overflow_alert = 1'b0;
    logic signed [15:0] accel_x = '0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, st, d, ra, rb;
    logic [7:0] adr [10] = '{8'h56, 8'h57, 8'h58, 8'h5A, 8'h5B, 8'h5C, 8'h5E, 8'h5F, 8'h73, 8'h74};
    int bad_count = 0, check_count = 0, seed = 14057, cycles = 0;
    motirq_host host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    motirq_top dut_u (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(sample_tick), .accel_x(accel_x),
        .accel_y(16'sh0000), .hpf_x(16'sh0000), .hpf_y(16'sh0000), .offset_step_weight(1'b0),
        .engine_event(engine_event), .hub_done(hub_done), .time_overflow_alert(time_overflow_alert),
        .interrupt_pin_a(pin_a), .interrupt_pin_b(pin_b));
    // Stored value of a register after the host's clean-up and the reserved bits
    function automatic logic [7:0] expv(input logic [7:0] a, input logic [7:0] v);
        case (a)
            ADDR_TAP_FILTER_LATCH_CFG: return v & MASK_TAP_FILTER_LATCH_CFG & (v[CFG0_LATCH] ? 8'hFF : 8'hBF);
            ADDR_TAP_X_THR: return v & MASK_TAP_X;
            ADDR_TAP_Y_THR: return v & MASK_TAP_Y;
            ADDR_WAKE_HOLD_TIME: return v & MASK_WAKE_HOLD_TIME;
            ADDR_PIN_A_RT, ADDR_PIN_B_RT: return v & MASK_ROUTE;
            default: return (v == 8'h80 && a >= ADDR_X_OFS) ? 8'h81 : v;
        endcase
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One sample period with a given X sample
    task automatic tick(input logic signed [15:0] x);
        @(posedge core_clk);
        sample_tick <= 1'b1;
        accel_x <= x;
        @(posedge core_clk);
        sample_tick <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    initial forever #10 core_clk = ~core_clk;
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (adr[i]) begin
            host_u.rd(adr[i], st);
            cmp(st, 8'h00);
            d = $random(seed);
            host_u.wr(adr[i], d);
            host_u.rd(adr[i], st);
            cmp(st, expv(adr[i], d));
        end
        host_u.rd(8'h00, st);
        cmp(st, 8'h00);
        $display("test registers done");
        repeat (24) begin
            ra = $random(seed);
            rb = $random(seed);
            host_u.wr(ADDR_PIN_A_RT, ra);
            host_u.wr(ADDR_PIN_B_RT, rb);
            {engine_event, hub_done, time_overflow_alert} <= 3'($random(seed));
            repeat (2) @(posedge core_clk);
            #1 cmp({7'h0, pin_a}, {7'h0, engine_event & ra[1] | hub_done & ra[0]});
            cmp({7'h0, pin_b}, {7'h0, engine_event & rb[1] | time_overflow_alert & rb[0]});
        end
        $display("test routing done");
        // Mid-run reset clears pins and shadows
        @(posedge core_clk);
        {engine_event, hub_done, time_overflow_alert} <= 3'h0;
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        #1 cmp({6'h0, pin_a, pin_b}, 8'h00);
        for (int en = 0; en < 2; en++) begin
            host_u.wr(ADDR_TAP_FILTER_LATCH_CFG, 8'h49);
            host_u.wr(ADDR_TAP_X_THR, 8'h01);
            host_u.wr(ADDR_TAP_Y_THR, {en[0], 7'h1F});
            host_u.wr(ADDR_TAP_TIMING, 8'h00);
            host_u.wr(ADDR_WAKE_THR, 8'h00);
            host_u.wr(ADDR_WAKE_HOLD_TIME, 8'h00);
            host_u.wr(ADDR_X_OFS, 8'h00);
            host_u.wr(ADDR_PIN_A_RT, 8'h40);
            host_u.rd(ADDR_EVT_STATUS, st);
            tick(16'sd2000);
            repeat (3) tick(16'sd0);
            repeat (6) @(posedge core_clk);
            #1 cmp({7'h0, pin_a}, {7'h0, en[0]});
            host_u.rd(ADDR_EVT_STATUS, st);
            cmp(st & (en ? 8'h25 : 8'h05), en ? 8'h25 : 8'h00);
            repeat (2) @(posedge core_clk);
            #1 cmp({7'h0, pin_a}, 8'h00);
        end
        $display("test tap latch done");
        summarize();
    end
endmodule
`default_nettype wire
